// *** design/ubg_uart.sv ***
`timescale 1ns/1ps
// Contract
// RL1 - Divider register byte-wide, zero after reset
// RL2 - Bit clock comes only from system clock
// RL3 - Bits 6:4 pick prescale 2^(field+1)
// RL4 - Bits 3:0 pick counter divide 16+k
// RL5 - Software never writes divisor code 1111
// RL6 - Bit rate is clock / (2^(n+1)(k+16))
// RL7 - Software never rewrites divider mid-transfer
// RL8 - 3AH, 01H give 9600, 115200 at 8MHz
// RL9 - Tolerance set by frame length and divisor
// RL10 - Frame: start, data, parity, stop bits
// RL11 - Mode register sets length, parity, stops
// RL12 - Parity even, odd, zero or none
// RL13 - Seven-bit transmit drops data bit 7
// RL14 - Seven-bit receive clears data bit 7
// RL15 - Receive errors recorded in status register
// RL16 - Parity code 00 none 01 zero 10 odd 11 even
// RL17 - Mode bit 3: 0 seven, 1 eight bits
// RL18 - Two stops on transmit, receiver checks one
// RL19 - Status: parity bit2, framing bit1, overrun bit0
// RL20 - Divider bit 7 reads zero, ignores writes
module ubg_uart import ubg_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Register access
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  // Event pulses
  output logic             tx_done,
  output logic             rx_done,
  output logic             rx_error
);

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ubg_tx_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} ubg_rx_t;

  logic [7:0]  baud_q;     // Divider setting
  logic [7:0]  mode_q;     // Serial mode
  logic [2:0]  stat_q;     // Error flags
  logic [7:0]  rxbuf_q;    // Received byte
  logic        rx_full_q;  // Byte not yet read
  logic [7:0]  rdata_q;    // Read data
  ubg_tx_t     tx_st_q;    // Transmit state
  logic [11:0] tx_sh_q;    // Outgoing frame, LSB first
  logic [3:0]  tx_left_q;  // Bits still to send
  ubg_rx_t     rx_st_q;    // Receive state
  logic [2:0]  rx_s_q;     // Pin synchroniser
  logic        rx_lvl_q;   // Filtered line level
  logic [9:0]  rx_sh_q;    // Sampled bits
  logic [3:0]  rx_idx_q;   // Next sample slot
  logic        tx_done_q;  // Transmit end pulse
  logic        rx_done_q;  // Receive end pulse
  logic        rx_err_q;   // Receive error pulse

  ubg_tick_if tx_tk ();
  ubg_tick_if rx_tk ();

  ////////////////////////////////////////////////////////////////////////
  // Access decode
  wire wr_mode  = wr_en && (addr == MODE_ADDR);
  wire wr_baud  = wr_en && (addr == BAUD_ADDR);
  wire wr_txd   = wr_en && (addr == TXD_ADDR);
  wire rd_rxb   = rd_en && (addr == RXB_ADDR);

  // Mode fields
  wire       tx_en    = mode_q[MODE_TXE];
  wire       rx_en    = mode_q[MODE_RXE];
  wire [1:0] par_sel  = mode_q[PS_LSB +: 2];
  wire       char8    = mode_q[MODE_CL];
  wire [3:0] char_len = char8 ? CHAR8 : CHAR7;            // see RL17
  wire [3:0] par_len  = {3'b000, par_sel != PAR_NONE};
  wire [3:0] stop_len = STOP_BITS + {3'b000, mode_q[MODE_SL]};
  wire [3:0] tx_len   = START_BITS + char_len + par_len + stop_len; // see RL11
  wire [3:0] rx_len   = char_len + par_len + STOP_BITS;   // see RL18

  ////////////////////////////////////////////////////////////////////////
  // Frame builder: start, data, parity, stops (idle ones)
  function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [7:0] m);
    logic [11:0] f;
    logic [7:0]  dv;
    logic [3:0]  p;
    logic        par;
    dv = m[MODE_CL] ? d : {1'b0, d[6:0]};                 // see RL13
    f  = 12'hFFF;
    f[0] = 1'b0;                                          // see RL10
    p  = 4'h1;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || m[MODE_CL]) begin
        f[p] = dv[i];
        p    = p + 4'h1;
      end
    end
    case (m[PS_LSB +: 2])                                 // see RL12
      PAR_ODD:  par = ~^dv;                               // see RL16
      PAR_EVEN: par = ^dv;
      default:  par = 1'b0;
    endcase
    if (m[PS_LSB +: 2] != PAR_NONE) begin
      f[p] = par;
    end
    return f;
  endfunction : tx_frame

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      baud_q <= BAUD_RST;                                 // see RL1
      mode_q <= MODE_RST;
    end else begin
      if (wr_baud) begin
        baud_q <= wdata & BAUD_WMASK;                     // see RL20
      end
      if (wr_mode) begin
        mode_q <= wdata & MODE_WMASK;
      end
    end
  end

  // Read data, registered; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        MODE_ADDR: rdata_q <= mode_q;
        STAT_ADDR: rdata_q <= {5'h00, stat_q};            // see RL15
        BAUD_ADDR: rdata_q <= baud_q;
        RXB_ADDR:  rdata_q <= rxbuf_q;
        default:   rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Transmitter; timer held while idle, divider assumed stable
  wire tx_start = wr_txd && tx_en && (tx_st_q == TX_IDLE);

  assign tx_tk.cfg     = baud_q;                          // see RL7
  assign tx_tk.restart = (tx_st_q != TX_SEND);

  ubg_bit_timer u_tx_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tk      (tx_tk.gen)
  );

  // Shift frame out one bit per bit tick
  always_ff @(posedge clk_sys) begin
    if (!resetn || !tx_en) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 12'hFFF;
      tx_left_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_sh_q   <= tx_frame(wdata, mode_q);
            tx_left_q <= tx_len;
            tx_st_q   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_tk.bit_tick) begin
            tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  assign txd = tx_sh_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Line input: three stages, level moves when last two agree
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_s_q   <= 3'b111;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_s_q <= {rx_s_q[1:0], rxd};
      if (rx_s_q[1] == rx_s_q[2]) begin
        rx_lvl_q <= rx_s_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: sample start at half bit, then at mid of each bit
  wire       rx_finish = (rx_st_q == RX_BITS) && (rx_idx_q == rx_len);
  wire [7:0] rx_data   = char8 ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]}; // see RL14
  wire       rx_par    = rx_sh_q[char_len];
  wire       rx_stop   = rx_sh_q[char_len + par_len];
  wire       pe_err    = par_sel[1] && ((^rx_data ^ rx_par) == par_sel[0]); // see RL16
  wire       fe_err    = !rx_stop;                        // see RL18
  wire       ove_err   = rx_full_q && !rd_rxb;            // see RL19
  wire       start_ok  = (rx_st_q == RX_START) && rx_tk.half_tick && !rx_lvl_q;

  assign rx_tk.cfg     = baud_q;
  assign rx_tk.restart = (rx_st_q == RX_IDLE) || start_ok; // see RL9

  ubg_bit_timer u_rx_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tk      (rx_tk.gen)
  );

  // Receive sequencing; disabling stops at once, clears samples; a frame ending in the first disabled cycle is still buffered
  always_ff @(posedge clk_sys) begin
    if (!resetn || !rx_en) begin
      rx_st_q  <= RX_IDLE;
      rx_idx_q <= 4'h0;
      rx_sh_q  <= 10'h000;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (!rx_lvl_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tk.half_tick) begin
            rx_st_q  <= rx_lvl_q ? RX_IDLE : RX_BITS;
            rx_idx_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_finish) begin
            rx_st_q <= RX_IDLE;
          end else if (rx_tk.bit_tick) begin
            rx_sh_q[rx_idx_q] <= rx_lvl_q;
            rx_idx_q          <= rx_idx_q + 4'h1;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Buffer and status; a finishing frame wins over a buffer read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rxbuf_q   <= 8'h00;
      rx_full_q <= 1'b0;
      stat_q    <= STAT_RST;
    end else if (rx_finish) begin
      rxbuf_q   <= rx_data;
      rx_full_q <= 1'b1;
      stat_q    <= {pe_err, fe_err, ove_err};             // see RL15
    end else if (rd_rxb) begin
      rx_full_q <= 1'b0;
      stat_q    <= STAT_RST;
    end
  end

  // Event pulses
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_done_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_err_q  <= 1'b0;
    end else begin
      tx_done_q <= (tx_st_q == TX_SEND) && tx_tk.bit_tick && (tx_left_q == 4'h1);
      rx_done_q <= rx_finish;
      rx_err_q  <= rx_finish && (pe_err || fe_err || ove_err);
    end
  end

  assign tx_done  = tx_done_q;
  assign rx_done  = rx_done_q;
  assign rx_error = rx_err_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  baud_reset_a: assert property (@(posedge clk_sys) // see RL1
    !resetn |=> baud_q == BAUD_RST)
    else $error("divider not cleared by reset");

  baud_top_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL20
    wr_baud |=> baud_q[7] == 1'b0 && baud_q[6:0] == $past(wdata[6:0]))
    else $error("divider write wrong");

  tx_start_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL10
    tx_start |=> !txd && tx_left_q == $past(tx_len))
    else $error("frame start wrong");

  tx_seven_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL13
    tx_start && !char8 && par_sel == PAR_NONE |=> tx_sh_q[8] == 1'b1)
    else $error("bit 7 sent in seven-bit mode");

  rx_seven_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL14
    rx_finish && !char8 |=> rx_done && rxbuf_q[7] == 1'b0)
    else $error("bit 7 not cleared");

  stat_record_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL19
    rx_finish |=> stat_q == $past({pe_err, fe_err, ove_err}) && rx_full_q)
    else $error("status not recorded");

  no_par_err_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL16
    rx_finish && !par_sel[1] |=> !stat_q[STAT_PE])
    else $error("parity error without checking");

  tx_end_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL11
    tx_done |-> txd && tx_st_q == TX_IDLE)
    else $error("transmit end wrong");

endmodule : ubg_uart

// *** design/ubg_pkg.sv ***
package ubg_pkg;

  // Register addresses
  localparam logic [15:0] MODE_ADDR  = 16'hFFA0;
  localparam logic [15:0] STAT_ADDR  = 16'hFFA1;
  localparam logic [15:0] BAUD_ADDR  = 16'hFFA2;
  localparam logic [15:0] TXD_ADDR   = 16'hFFA4;
  localparam logic [15:0] RXB_ADDR   = 16'hFFA5;

  // Values after reset and write masks
  localparam logic [7:0]  BAUD_RST   = 8'h00;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [2:0]  STAT_RST   = 3'h0;
  localparam logic [7:0]  BAUD_WMASK = 8'h7F;
  localparam logic [7:0]  MODE_WMASK = 8'hFE;

  // Divider field positions
  localparam int          PRE_LSB    = 4;
  localparam int          DIV_LSB    = 0;
  localparam logic [4:0]  BASE_DIV   = 5'h10;

  // Mode field positions
  localparam int          MODE_TXE   = 7;
  localparam int          MODE_RXE   = 6;
  localparam int          PS_LSB     = 4;
  localparam int          MODE_CL    = 3;
  localparam int          MODE_SL    = 2;

  // Status field positions
  localparam int          STAT_PE    = 2;
  localparam int          STAT_FE    = 1;
  localparam int          STAT_OVE   = 0;

  // Frame bit counts
  localparam logic [3:0]  CHAR7      = 4'h7;
  localparam logic [3:0]  CHAR8      = 4'h8;
  localparam logic [3:0]  START_BITS = 4'h1;
  localparam logic [3:0]  STOP_BITS  = 4'h1;

  // Parity kinds
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } ubg_par_t;

  // System clocks per serial bit: 2^(n+1) * (16 + k), n = field + 1
  function automatic int unsigned ubg_bit_cycles(input logic [7:0] c);
    return (32'd2 << ({29'd0, c[PRE_LSB +: 3]} + 32'd1)) * (32'd16 + {28'd0, c[DIV_LSB +: 4]});
  endfunction : ubg_bit_cycles

endpackage : ubg_pkg

// *** design/ubg_tick_if.sv ***
`timescale 1ns/1ps
interface ubg_tick_if;
  logic       restart;    // Hold timer at phase zero
  logic [7:0] cfg;        // Divider setting
  logic       half_tick;  // Every 5-bit counter wrap
  logic       bit_tick;   // Every second wrap
  modport gen  (input restart, input cfg, output half_tick, output bit_tick);
  modport user (output restart, output cfg, input half_tick, input bit_tick);
endinterface : ubg_tick_if

// *** design/ubg_bit_timer.sv ***
`timescale 1ns/1ps
module ubg_bit_timer import ubg_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Timer link
  ubg_tick_if.gen  tk
);

  logic [7:0]  pre_q;    // Power-of-two prescaler
  logic [4:0]  cnt_q;    // 5-bit counter
  logic        phase_q;  // Second half of bit
  logic [15:0] per_q;    // Cycles since last bit tick

  // Prescale top 2^n - 1 and counter top 15 + k
  wire [2:0] pre_sel  = tk.cfg[PRE_LSB +: 3];
  wire [3:0] div_k    = tk.cfg[DIV_LSB +: 4];
  wire [7:0] pre_top  = 8'((9'd2 << pre_sel) - 9'd1);   // see RL3
  wire [4:0] cnt_top  = BASE_DIV - 5'h01 + {1'b0, div_k}; // see RL4
  wire       src_tick = (pre_q == pre_top);
  wire       wrap     = src_tick && (cnt_q == cnt_top);

  assign tk.half_tick = wrap;
  assign tk.bit_tick  = wrap && phase_q;  // see RL6

  ////////////////////////////////////////////////////////////////////////
  // Divider chain, derived from the system clock only
  always_ff @(posedge clk_sys) begin  // see RL2
    if (!resetn || tk.restart) begin
      pre_q   <= 8'h00;
      cnt_q   <= 5'h00;
      phase_q <= 1'b0;
    end else begin
      pre_q <= src_tick ? 8'h00 : pre_q + 8'h01;
      if (src_tick) begin
        cnt_q <= wrap ? 5'h00 : cnt_q + 5'h01;
      end
      if (wrap) begin
        phase_q <= ~phase_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Period counter for checks
  always_ff @(posedge clk_sys) begin
    if (!resetn || tk.restart || tk.bit_tick) begin
      per_q <= 16'h0001;
    end else begin
      per_q <= per_q + 16'h0001;
    end
  end

  bit_period_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL8
    tk.bit_tick && !tk.restart |-> per_q == 16'(ubg_bit_cycles(tk.cfg)))
    else $error("bit period wrong");

  half_first_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see RL9
    tk.half_tick && !phase_q && !tk.restart |->
      2 * per_q == 16'(ubg_bit_cycles(tk.cfg)))
    else $error("half bit point wrong");

endmodule : ubg_bit_timer

// *** test/ubg_remote.sv ***
`timescale 1ns/1ps
module ubg_remote (
  // Clock
  input  wire logic clk_sys,
  // Serial line
  input  wire logic txd,
  output logic      rxd
);

  ////////////////////////////////////////////////////////////////////////////
  // Line idles high between frames
  initial rxd = 1'b1;

  // Send one frame, LSB first, each bit one full period
  task automatic send(input logic [11:0] f, input int nb, input int p);
    for (int i = 0; i < nb; i++) begin
      rxd = f[i];
      repeat (p) @(negedge clk_sys);
    end
    rxd = 1'b1;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////
  // Capture one frame: start width in cycles, then mid-bit samples
  task automatic grab(input int nb, input int p, output logic [11:0] f, output int w);
    int guard;
    f     = 12'hfff;
    w     = 0;
    guard = 0;
    // Bounded wait for the start edge
    while (txd !== 1'b0 && guard < 16) begin
      @(negedge clk_sys);
      guard++;
    end
    // Width of the start bit
    while (txd === 1'b0 && w < 4 * p) begin
      @(negedge clk_sys);
      w++;
    end
    f[0] = 1'b0;
    repeat (p / 2) @(negedge clk_sys);
    // Remaining bits sampled in their middle
    for (int i = 1; i < nb; i++) begin
      f[i] = txd;
      if (i < nb - 1) begin
        repeat (p) @(negedge clk_sys);
      end
    end
  endtask : grab

endmodule : ubg_remote

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench import ubg_pkg::*;;
  // Clock, reset and register access
  logic        clk_sys;
  logic        resetn;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  // Serial line and events
  logic        rxd;
  logic        txd;
  logic        tx_done;
  logic        rx_done;
  logic        rx_error;
  // Bookkeeping
  int          n_errors;
  int          comparisons;
  int          cycles;

  ubg_uart ubg_uart_i (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd),
    .tx_done(tx_done), .rx_done(rx_done), .rx_error(rx_error));
  ubg_remote ubg_remote_i (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write, one-cycle strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask : wr

  // Register read, data valid the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
    d     = rdata;
  endtask : rd

  // Value comparison
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Bounded wait for a completion pulse; reports the error pulse beside it
  task automatic wait_evt(input logic rx, input int lim, output logic err);
    int c;
    c = 0;
    @(negedge clk_sys);
    while (((rx ? rx_done : tx_done) !== 1'b1) && c < lim) begin
      @(negedge clk_sys);
      c++;
    end
    chk("done_pulse", 16'h0001, {15'h0000, c < lim});
    err = rx_error;
  endtask : wait_evt

  // Expected frame bits from mode and data
  function automatic int build(input logic [7:0] m, input logic [7:0] d,
                               output logic [11:0] f);
    int         nb;
    logic [7:0] v;
    v  = m[MODE_CL] ? d : {1'b0, d[6:0]};
    f  = m[MODE_CL] ? {3'b111, v, 1'b0} : {4'b1111, v[6:0], 1'b0};
    nb = m[MODE_CL] ? 9 : 8;
    if (m[PS_LSB +: 2] != 2'b00) begin
      f[nb] = (m[PS_LSB +: 2] == 2'b01) ? 1'b0 : (m[PS_LSB +: 2] == 2'b10) ? ~^v : ^v;
      nb++;
    end
    return nb + (m[MODE_SL] ? 2 : 1);
  endfunction : build

  // Verdict
  task automatic complete_run();
    $display("Comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Test tables
  logic [7:0]  tx_baud [5] = '{8'h00, 8'h01, 8'h0e, 8'h3a, 8'h10};
  logic [7:0]  tx_mode [5] = '{8'hc8, 8'hd8, 8'he4, 8'hfc, 8'he0};
  logic [7:0]  tx_data [5] = '{8'ha5, 8'h37, 8'hb3, 8'h81, 8'hff};
  logic [7:0]  rx_mode [7] = '{8'h7c, 8'h64, 8'h7c, 8'h7c, 8'h5c, 8'h48, 8'h48};
  logic [7:0]  rx_data [7] = '{8'h5a, 8'hc1, 8'h5a, 8'h5a, 8'h5a, 8'h11, 8'h22};
  logic [11:0] rx_flip [7] = '{12'h000, 12'h000, 12'h200, 12'h400, 12'h200, 12'h000, 12'h000};
  logic [7:0]  rx_stat [7] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h01};
  logic [7:0]  rx_exp  [7] = '{8'h5a, 8'h41, 8'h5a, 8'h5a, 8'h5a, 8'h11, 8'h22};
  logic        rx_rd   [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0]  v;
    logic [11:0] fe;
    logic [11:0] fg;
    logic        e;
    int          p;
    int          nb;
    int          w;
    n_errors    = 0;
    comparisons = 0;
    cycles      = 0;
    resetn      = 1'b0;
    addr        = 16'h0000;
    wdata       = 8'h00;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    // Reset values, masked bit, unmapped place
    rd(BAUD_ADDR, v); chk("baud_reset", 16'h0000, v);
    rd(MODE_ADDR, v); chk("mode_reset", 16'h0000, v);
    rd(STAT_ADDR, v); chk("stat_reset", 16'h0000, v);
    wr(BAUD_ADDR, 8'h8e);
    rd(BAUD_ADDR, v); chk("baud_bit7", 16'h000e, v);
    rd(16'hffa3, v); chk("unmapped", 16'h0000, v);
    // Transmit: divider codes, parity kinds, lengths; divider written between frames
    for (int i = 0; i < 5; i++) begin
      p = (1 << (tx_baud[i][6:4] + 2)) * (16 + tx_baud[i][3:0]);
      wr(BAUD_ADDR, tx_baud[i]);
      wr(MODE_ADDR, tx_mode[i]);
      nb = build(tx_mode[i], tx_data[i], fe);
      fork
        wr(TXD_ADDR, tx_data[i]);
        ubg_remote_i.grab(nb, p, fg, w);
      join
      chk("tx_frame", fe, fg);
      chk("tx_bit_time", p[15:0], w[15:0]);
      wait_evt(1'b0, p, e);
      chk("tx_idle", 16'h0001, {15'h0000, txd});
    end
    // Receive: good, seven-bit, parity, framing, zero parity, overrun
    wr(BAUD_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(MODE_ADDR, rx_mode[i]);
      nb = build(rx_mode[i] & 8'hfb, rx_data[i], fe);
      fork
        ubg_remote_i.send(fe ^ rx_flip[i], nb, 64);
        wait_evt(1'b1, (nb + 2) * 64, e);
      join
      chk("rx_error", {15'h0000, rx_stat[i] != 8'h00}, {15'h0000, e});
      if (rx_rd[i]) begin
        rd(STAT_ADDR, v); chk("rx_status", rx_stat[i], v);
        rd(RXB_ADDR, v); chk("rx_data", rx_exp[i], v);
      end
    end
    rd(STAT_ADDR, v); chk("stat_cleared", 16'h0000, v);
    complete_run();
  end

endmodule : testbench
